//--- hw/ens_defines.svh
// Constants for the end node sleep controller: offsets, fields, resets, timing.
// Assumes a 125 MHz clock and an APB slave with 32-bit word registers.
//
// Overview of operation
// - Mode 1 follows the sleep request pin.
// - Modes 4 and 5 sleep then wake to poll.
// - Mode 5 also wakes on falling request edge.
// - Mode 4 ignores the request pin for waking.
// - Poll the parent every 100 ms awake.
// - Receiver on until ack; pending keeps it on.
// - Awake indicator high awake, low asleep.
// - With flow control, CTS high asleep, low awake.
// - Link LED forced low during sleep.
// - Request pin pulled down while asleep.
// - Asleep: other pins kept, serial and radio ignored.
// - Unjoined device scans channel mask on wake.
// - Pin sleep waits for transfers and scans.
// - Pin mode wakes when request goes low.
// - First poll 1-2 ms after pin wake.
// - Cyclic wake stays only for data.
// - Serial or radio bytes restart wake-hold timer.
// - Sleep on timer expiry or sleep command.
// - Sleep period 0x20..0xAF0 in 10 ms units.
// - Period count 1..0xFFFF multiplies the period.
// - Option 0x02 full hold, 0x04 extended sleep.
// - Count above 1 raises indicator only selectively.
`ifndef ENS_DEFINES_SVH
`define ENS_DEFINES_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ENS_OFF_MODE 12'h000
`define ENS_OFF_PERIOD 12'h004
`define ENS_OFF_COUNT 12'h008
`define ENS_OFF_OPTIONS 12'h00C
`define ENS_OFF_HOLD 12'h010
`define ENS_OFF_CONFIG 12'h014
`define ENS_OFF_COMMAND 12'h018
`define ENS_OFF_STATUS 12'h01C
// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define ENS_CFG_CTS_BIT 0
`define ENS_CFG_LED_BIT 1
`define ENS_CFG_LEDVAL_BIT 2
`define ENS_CMD_SLEEP_BIT 0
`define ENS_OPT_FULL_HOLD_BIT 1
`define ENS_OPT_EXTENDED_BIT 2
`define ENS_MODE_PIN 3'h1
`define ENS_MODE_CYCLIC 3'h4
`define ENS_MODE_CYCLIC_PIN 3'h5
`define ENS_PERIOD_MIN 12'h020
`define ENS_PERIOD_MAX 12'hAF0
`define ENS_COUNT_MIN 16'h0001
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ENS_RST_MODE 3'h0
`define ENS_RST_PERIOD 12'h020
`define ENS_RST_COUNT 16'h0001
`define ENS_RST_OPTIONS 8'h00
`define ENS_RST_HOLD 16'h0005
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ENS_CLK_MHZ 125
`define ENS_TICK_US 10000
`define ENS_TICK_CYC (`ENS_TICK_US * `ENS_CLK_MHZ)
`define ENS_POLL_MS 100
`define ENS_POLL_TICKS (`ENS_POLL_MS / 10)
`define ENS_FIRST_POLL_US 1000
`define ENS_FIRST_POLL_CYC (`ENS_FIRST_POLL_US * `ENS_CLK_MHZ)
`endif

//--- hw/ens_pkg.sv
// Types shared by the end node sleep controller.
// Assumes ens_defines.svh is compiled alongside.
package ens_pkg;
  // Power state of the node
  typedef enum logic [1:0] {ENS_AWAKE, ENS_DRAIN, ENS_ASLEEP} ens_state_e;
  // Poll sequence state
  typedef enum logic [1:0] {ENS_P_IDLE, ENS_P_WAIT_ACK, ENS_P_RX} ens_poll_e;
endpackage

//--- hw/ens_sleep_ctrl.sv
// Sleep controller for a battery-powered wireless end node.
// Assumes an APB master on CLK_I and a radio/serial stack that reports events as pulses.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "ens_defines.svh"
module ens_sleep_ctrl #(
  parameter int TICK_CYC = `ENS_TICK_CYC,
  parameter int FIRST_POLL_CYC = `ENS_FIRST_POLL_CYC
)(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SLEEP_REQUEST_PIN_I,
  input wire logic STACK_BUSY_I,
  input wire logic JOINED_I,
  input wire logic POLL_ACK_I,
  input wire logic POLL_PENDING_I,
  input wire logic RADIO_BYTE_I,
  input wire logic SERIAL_BYTE_I,
  input wire logic RX_DONE_I,
  output logic POLL_REQ_O,
  output logic RX_ENABLE_O,
  output logic SCAN_START_O,
  output logic AWAKE_O,
  output logic CTS_O,
  output logic LINK_LED_O,
  output logic REQ_PULLDOWN_O,
  output logic SERIAL_ACCEPT_O,
  output logic RADIO_ACCEPT_O
);
  import ens_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [2:0] sleep_mode_select_r; // Mode selector
  logic [11:0] sleep_period_r; // Base period, 10 ms units
  logic [15:0] sleep_period_count_r; // Period multiplier
  logic [7:0] sleep_options_r; // Option bits
  logic [15:0] wake_hold_timer_r; // Hold time, 10 ms units
  logic cts_flow_enable_r; // Hardware flow control on
  logic link_led_config_r; // LED pin configured
  logic link_led_value_r; // Configured LED level
  logic sleep_cmd_r; // Sleep-immediately pulse
  ens_state_e state_r; // Power state
  ens_poll_e poll_r; // Poll state
  logic req_meta_r; // Synchroniser stage one
  logic req_sync_r; // Synchronised request
  logic req_prev_r; // For edge detect
  logic [23:0] tick_cnt_r; // 10 ms prescaler
  logic tick; // One 10 ms tick
  logic [27:0] sleep_left_r; // Ticks left asleep
  logic [15:0] hold_left_r; // Ticks left awake
  logic hold_run_r; // Hold timer active
  logic [3:0] poll_ticks_r; // Ticks to next poll
  logic [16:0] first_poll_r; // First poll delay
  logic [15:0] cycle_cnt_r; // Silent wake cycles
  logic indicate_r; // Indicator permitted
  logic wake_ev; // Wake event this cycle
  logic apb_wr;
  logic apb_rd;
  logic cyclic;
  logic asleep;
  logic data_ev;
  logic [27:0] sleep_total;

  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign apb_rd = PSEL_I && PENABLE_I && !PWRITE_I;
  assign cyclic = (sleep_mode_select_r == `ENS_MODE_CYCLIC) ||
                  (sleep_mode_select_r == `ENS_MODE_CYCLIC_PIN);
  assign asleep = (state_r == ENS_ASLEEP);
  // Bytes count only while awake; asleep input is ignored
  assign data_ev = !asleep && (RADIO_BYTE_I || SERIAL_BYTE_I);
  // Extended sleep multiplies, short sleep uses the base period
  assign sleep_total = sleep_options_r[`ENS_OPT_EXTENDED_BIT] ?
                       28'(sleep_period_r * sleep_period_count_r) :
                       28'(sleep_period_r);

  // ------------------------------------------------------------
  // Request pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
      req_prev_r <= 1'b0;
    end
    else
    begin
      req_meta_r <= SLEEP_REQUEST_PIN_I;
      req_sync_r <= req_meta_r;
      req_prev_r <= req_sync_r;
    end
  end

  // ------------------------------------------------------------
  // APB register writes
  // ------------------------------------------------------------
  // Out-of-range settings are clamped so the timers never see zero
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sleep_mode_select_r <= `ENS_RST_MODE;
      sleep_period_r <= `ENS_RST_PERIOD;
      sleep_period_count_r <= `ENS_RST_COUNT;
      sleep_options_r <= `ENS_RST_OPTIONS;
      wake_hold_timer_r <= `ENS_RST_HOLD;
      cts_flow_enable_r <= 1'b0;
      link_led_config_r <= 1'b0;
      link_led_value_r <= 1'b0;
      sleep_cmd_r <= 1'b0;
    end
    else
    begin
      sleep_cmd_r <= 1'b0;
      if (apb_wr)
      begin
        if (PADDR_I == `ENS_OFF_MODE)
          sleep_mode_select_r <= PWDATA_I[2:0];
        else if (PADDR_I == `ENS_OFF_PERIOD)
        begin
          // Period bounded to its legal range
          if (PWDATA_I[11:0] < `ENS_PERIOD_MIN || PWDATA_I[31:12] != 20'h00000)
            sleep_period_r <= (PWDATA_I[31:12] != 20'h00000) ? `ENS_PERIOD_MAX :
                              `ENS_PERIOD_MIN;
          else if (PWDATA_I[11:0] > `ENS_PERIOD_MAX)
            sleep_period_r <= `ENS_PERIOD_MAX;
          else
            sleep_period_r <= PWDATA_I[11:0];
        end
        else if (PADDR_I == `ENS_OFF_COUNT)
          sleep_period_count_r <= (PWDATA_I[15:0] == 16'h0000) ? `ENS_COUNT_MIN :
                                  PWDATA_I[15:0];
        else if (PADDR_I == `ENS_OFF_OPTIONS)
          sleep_options_r <= PWDATA_I[7:0];
        else if (PADDR_I == `ENS_OFF_HOLD)
          wake_hold_timer_r <= (PWDATA_I[15:0] == 16'h0000) ? 16'h0001 : PWDATA_I[15:0];
        else if (PADDR_I == `ENS_OFF_CONFIG)
        begin
          cts_flow_enable_r <= PWDATA_I[`ENS_CFG_CTS_BIT];
          link_led_config_r <= PWDATA_I[`ENS_CFG_LED_BIT];
          link_led_value_r <= PWDATA_I[`ENS_CFG_LEDVAL_BIT];
        end
        else if (PADDR_I == `ENS_OFF_COMMAND)
          sleep_cmd_r <= PWDATA_I[`ENS_CMD_SLEEP_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // APB read data and response
  // ------------------------------------------------------------
  // Zero wait states: ready in every access cycle
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PRDATA_O <= 32'h00000000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      if (PSEL_I && !PENABLE_I && !PWRITE_I)
      begin
        if (PADDR_I == `ENS_OFF_MODE)
          PRDATA_O <= {29'h0, sleep_mode_select_r};
        else if (PADDR_I == `ENS_OFF_PERIOD)
          PRDATA_O <= {20'h0, sleep_period_r};
        else if (PADDR_I == `ENS_OFF_COUNT)
          PRDATA_O <= {16'h0, sleep_period_count_r};
        else if (PADDR_I == `ENS_OFF_OPTIONS)
          PRDATA_O <= {24'h0, sleep_options_r};
        else if (PADDR_I == `ENS_OFF_HOLD)
          PRDATA_O <= {16'h0, wake_hold_timer_r};
        else if (PADDR_I == `ENS_OFF_CONFIG)
          PRDATA_O <= {29'h0, link_led_value_r, link_led_config_r, cts_flow_enable_r};
        else if (PADDR_I == `ENS_OFF_STATUS)
          PRDATA_O <= {26'h0, poll_r, state_r, hold_run_r, req_sync_r};
        else if (PADDR_I == `ENS_OFF_COMMAND)
          PRDATA_O <= 32'h00000000;
        else
          PSLVERR_O <= 1'b1; // Unmapped address
      end
      else if (PSEL_I && !PENABLE_I)
      begin
        // Unmapped write flagged the same way
        if (PADDR_I > `ENS_OFF_STATUS || PADDR_I[1:0] != 2'h0)
          PSLVERR_O <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // 10 ms tick prescaler
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      tick_cnt_r <= 24'h000000;
    else if (tick)
      tick_cnt_r <= 24'h000000;
    else
      tick_cnt_r <= tick_cnt_r + 24'h000001;
  end
  assign tick = (tick_cnt_r == 24'(TICK_CYC - 1));

  // ------------------------------------------------------------
  // Wake sources
  // ------------------------------------------------------------
  always_comb
  begin
    wake_ev = 1'b0;
    if (sleep_mode_select_r == `ENS_MODE_PIN)
      wake_ev = !req_sync_r;
    else if (sleep_mode_select_r == `ENS_MODE_CYCLIC_PIN)
      wake_ev = (tick && sleep_left_r <= 28'h1) ||
                (req_prev_r && !req_sync_r);
    else if (sleep_mode_select_r == `ENS_MODE_CYCLIC)
      wake_ev = tick && sleep_left_r <= 28'h1;
    else
      wake_ev = 1'b1;
  end

  // ------------------------------------------------------------
  // Power state machine
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state_r <= ENS_AWAKE;
    else
    begin
      case (state_r)
        ENS_AWAKE:
        begin
          if (sleep_mode_select_r == `ENS_MODE_PIN && req_sync_r)
            state_r <= ENS_DRAIN;
          else if (cyclic && (sleep_cmd_r || (hold_run_r && tick &&
                   hold_left_r <= 16'h1)))
            state_r <= ENS_DRAIN;
          else if (cyclic && !hold_run_r && poll_r == ENS_P_WAIT_ACK && POLL_ACK_I &&
                   !POLL_PENDING_I && !sleep_options_r[`ENS_OPT_FULL_HOLD_BIT])
            state_r <= ENS_DRAIN;
        end
        ENS_DRAIN:
        begin
          if (!cyclic && sleep_mode_select_r != `ENS_MODE_PIN)
            state_r <= ENS_AWAKE;
          else if (sleep_mode_select_r == `ENS_MODE_PIN && !req_sync_r)
            state_r <= ENS_AWAKE;
          else if (!STACK_BUSY_I)
            state_r <= ENS_ASLEEP;
        end
        ENS_ASLEEP:
        begin
          if (wake_ev)
            state_r <= ENS_AWAKE;
        end
        default:
          state_r <= ENS_AWAKE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sleep period counter
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sleep_left_r <= 28'h0000000;
    else if (state_r != ENS_ASLEEP)
      sleep_left_r <= sleep_total; // 10 ms units
    else if (tick && sleep_left_r != 28'h0)
      sleep_left_r <= sleep_left_r - 28'h1;
  end

  // ------------------------------------------------------------
  // Wake-hold timer
  // ------------------------------------------------------------
  // Each byte reloads; full-hold option arms it at every wake
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      hold_run_r <= 1'b0;
      hold_left_r <= 16'h0000;
    end
    else if (!cyclic || state_r != ENS_AWAKE)
    begin
      hold_run_r <= 1'b0;
      hold_left_r <= wake_hold_timer_r;
    end
    else if (data_ev || (!hold_run_r && (sleep_options_r[`ENS_OPT_FULL_HOLD_BIT] ||
             (poll_r == ENS_P_WAIT_ACK && POLL_ACK_I && POLL_PENDING_I))))
    begin
      hold_run_r <= 1'b1;
      hold_left_r <= wake_hold_timer_r;
    end
    else if (hold_run_r && tick && hold_left_r != 16'h0)
      hold_left_r <= hold_left_r - 16'h1;
  end

  // ------------------------------------------------------------
  // Poll scheduling and receiver gating
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      poll_r <= ENS_P_IDLE;
      poll_ticks_r <= 4'h0;
      first_poll_r <= 17'h00000;
      POLL_REQ_O <= 1'b0;
      RX_ENABLE_O <= 1'b0;
    end
    else
    begin
      POLL_REQ_O <= 1'b0;
      if (state_r == ENS_ASLEEP)
      begin
        poll_r <= ENS_P_IDLE;
        poll_ticks_r <= 4'h0;
        first_poll_r <= 17'(FIRST_POLL_CYC);
        RX_ENABLE_O <= 1'b0;
      end
      else
      begin
        if (first_poll_r != 17'h0)
          first_poll_r <= first_poll_r - 17'h1;
        if (tick && poll_ticks_r != 4'h0)
          poll_ticks_r <= poll_ticks_r - 4'h1;
        case (poll_r)
          ENS_P_IDLE:
          begin
            if (JOINED_I && first_poll_r <= 17'h1 && poll_ticks_r == 4'h0)
            begin
              POLL_REQ_O <= 1'b1;
              RX_ENABLE_O <= 1'b1;
              poll_ticks_r <= 4'(`ENS_POLL_TICKS);
              poll_r <= ENS_P_WAIT_ACK;
            end
          end
          ENS_P_WAIT_ACK:
          begin
            if (POLL_ACK_I)
            begin
              RX_ENABLE_O <= POLL_PENDING_I;
              poll_r <= POLL_PENDING_I ? ENS_P_RX : ENS_P_IDLE;
            end
          end
          ENS_P_RX:
          begin
            if (RX_DONE_I)
            begin
              RX_ENABLE_O <= 1'b0;
              poll_r <= ENS_P_IDLE;
            end
          end
          default:
            poll_r <= ENS_P_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Silent polling cycle count
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cycle_cnt_r <= 16'h0000;
      indicate_r <= 1'b1;
    end
    else if (!cyclic || sleep_period_count_r == 16'h0001)
    begin
      cycle_cnt_r <= 16'h0000;
      indicate_r <= 1'b1;
    end
    else if (state_r == ENS_ASLEEP && wake_ev)
    begin
      // Count wake cycles; the Nth one shows
      if (cycle_cnt_r + 16'h1 >= sleep_period_count_r)
      begin
        cycle_cnt_r <= 16'h0000;
        indicate_r <= 1'b1;
      end
      else
      begin
        cycle_cnt_r <= cycle_cnt_r + 16'h1;
        indicate_r <= 1'b0;
      end
    end
    else if (state_r == ENS_AWAKE && RADIO_BYTE_I)
      indicate_r <= 1'b1;
  end

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      AWAKE_O <= 1'b0;
      CTS_O <= 1'b0;
      LINK_LED_O <= 1'b0;
      REQ_PULLDOWN_O <= 1'b0;
      SERIAL_ACCEPT_O <= 1'b0;
      RADIO_ACCEPT_O <= 1'b0;
      SCAN_START_O <= 1'b0;
    end
    else
    begin
      AWAKE_O <= (state_r != ENS_ASLEEP) && indicate_r;
      CTS_O <= cts_flow_enable_r && (state_r == ENS_ASLEEP);
      LINK_LED_O <= link_led_config_r && link_led_value_r &&
                    (state_r != ENS_ASLEEP);
      REQ_PULLDOWN_O <= (state_r == ENS_ASLEEP);
      SERIAL_ACCEPT_O <= (state_r != ENS_ASLEEP);
      RADIO_ACCEPT_O <= (state_r != ENS_ASLEEP);
      // Scan pulse lands as the pull-down lets go, so it never shows while asleep
      SCAN_START_O <= REQ_PULLDOWN_O && (state_r != ENS_ASLEEP) && !JOINED_I;
    end
  end
endmodule

//--- verification/ens_sleep_chk.sv
// Port-level checker for the end node sleep controller.
// Assumes a shortened tick, so polls still lie more than 8 cycles apart.
`timescale 1ns/1ps
module ens_sleep_chk (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic STACK_BUSY_I,
  input wire logic JOINED_I,
  input wire logic POLL_ACK_I,
  input wire logic POLL_PENDING_I,
  input logic POLL_REQ_O,
  input logic RX_ENABLE_O,
  input logic SCAN_START_O,
  input logic AWAKE_O,
  input logic CTS_O,
  input logic LINK_LED_O,
  input logic REQ_PULLDOWN_O,
  input logic SERIAL_ACCEPT_O,
  input logic RADIO_ACCEPT_O
);
  // ----------------------------------------
  // Single domain, so one clock and reset
  // ----------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // The pull-down marks the asleep state at the pins
  a_awake_off_asleep: assert property (REQ_PULLDOWN_O |-> !AWAKE_O)
    else $error("awake high while asleep");
  a_cts_only_asleep: assert property (CTS_O |-> REQ_PULLDOWN_O)
    else $error("serial blocked while awake");
  a_led_dark_asleep: assert property (REQ_PULLDOWN_O |-> !LINK_LED_O)
    else $error("link LED lit while asleep");
  a_deaf_while_asleep: assert property (REQ_PULLDOWN_O |-> !(SERIAL_ACCEPT_O || RADIO_ACCEPT_O))
    else $error("input accepted while asleep");
  a_poll_rx_on: assert property (POLL_REQ_O |-> ##[0:1] RX_ENABLE_O)
    else $error("receiver off after poll");
  a_poll_spacing: assert property (POLL_REQ_O |=> !POLL_REQ_O [*8])
    else $error("polls too close");
  a_ack_rx_off: assert property (POLL_ACK_I && !POLL_PENDING_I && RX_ENABLE_O
    |-> ##[1:2] !RX_ENABLE_O)
    else $error("receiver left on without data");
  // Two busy cycles in a row leave no room for the sleep state to land
  a_busy_holds_wake: assert property (STACK_BUSY_I && $past(STACK_BUSY_I) && !REQ_PULLDOWN_O
    |=> !REQ_PULLDOWN_O)
    else $error("slept during busy stack");
  a_scan_unjoined: assert property (SCAN_START_O |-> !JOINED_I && !REQ_PULLDOWN_O)
    else $error("scan while joined or asleep");
endmodule
bind ens_sleep_ctrl ens_sleep_chk u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .STACK_BUSY_I(STACK_BUSY_I), .JOINED_I(JOINED_I), .POLL_ACK_I(POLL_ACK_I),
  .POLL_PENDING_I(POLL_PENDING_I), .POLL_REQ_O(POLL_REQ_O), .RX_ENABLE_O(RX_ENABLE_O),
  .SCAN_START_O(SCAN_START_O), .AWAKE_O(AWAKE_O), .CTS_O(CTS_O), .LINK_LED_O(LINK_LED_O),
  .REQ_PULLDOWN_O(REQ_PULLDOWN_O), .SERIAL_ACCEPT_O(SERIAL_ACCEPT_O),
  .RADIO_ACCEPT_O(RADIO_ACCEPT_O));

//--- verification/ens_parent_model.sv
// Parent node and host serial model on the far side of the controller.
// Assumes the bench sets ack delay and pending flag ahead of each poll.
`timescale 1ns/1ps
module ens_parent_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic poll_req_i,
  input wire logic rx_enable_i,
  input wire logic cts_i,
  input wire logic ser_go_i,
  input wire logic [3:0] ack_dly_i,
  input wire logic pend_i,
  output logic ack_o,
  output logic pending_o,
  output logic radio_byte_o,
  output logic serial_byte_o,
  output logic rx_done_o
);
  int cnt; // Cycles left to ack, -1 idle
  int rx_left; // Buffered bytes still owed
  // Ack after a chosen delay; buffered bytes only reach an open receiver
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= -1;
      rx_left <= 0;
      ack_o <= 1'h0;
      pending_o <= 1'h0;
      radio_byte_o <= 1'h0;
      rx_done_o <= 1'h0;
      serial_byte_o <= 1'h0;
    end
    else
    begin
      ack_o <= cnt == 0;
      pending_o <= (cnt == 0) ? pend_i : !pending_o; // Junk outside the ack
      cnt <= poll_req_i ? int'(ack_dly_i) : (cnt >= 0 ? cnt - 1 : -1);
      if (cnt == 0 && pend_i)
        rx_left <= 3;
      else if (rx_left > 0 && rx_enable_i)
        rx_left <= rx_left - 1;
      radio_byte_o <= rx_left > 1 && rx_enable_i;
      rx_done_o <= rx_left == 1 && rx_enable_i;
      serial_byte_o <= ser_go_i && !cts_i; // Host holds off on CTS
    end
  end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the end node sleep controller.
// Assumes a 10-cycle tick and 5 cycles to the first poll.
`timescale 1ns/1ps
`include "ens_defines.svh"
module testbench;
  logic CLK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
  logic [11:0] PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, rd, v;
  logic SLEEP_REQUEST_PIN_I, STACK_BUSY_I, JOINED_I, POLL_ACK_I, POLL_PENDING_I;
  logic RADIO_BYTE_I, SERIAL_BYTE_I, RX_DONE_I, POLL_REQ_O, RX_ENABLE_O, SCAN_START_O;
  logic AWAKE_O, CTS_O, LINK_LED_O, REQ_PULLDOWN_O, SERIAL_ACCEPT_O, RADIO_ACCEPT_O;
  logic ser_go, pend;
  logic [3:0] ack_dly;
  logic [31:0] seed = 32'h0000000C;
  int err_total, n_checks, n;
  ens_sleep_ctrl #(.TICK_CYC(10), .FIRST_POLL_CYC(5)) dut (.*);
  ens_parent_model u_par (.clk_i(CLK_I), .rst_n_i(RST_N_I), .poll_req_i(POLL_REQ_O),
    .rx_enable_i(RX_ENABLE_O), .cts_i(CTS_O), .ser_go_i(ser_go), .ack_dly_i(ack_dly),
    .pend_i(pend), .ack_o(POLL_ACK_I), .pending_o(POLL_PENDING_I),
    .radio_byte_o(RADIO_BYTE_I), .serial_byte_o(SERIAL_BYTE_I), .rx_done_o(RX_DONE_I));
  // 125 MHz clock
  initial
  begin
    CLK_I = 1'h0;
    forever #4 CLK_I = ~CLK_I;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Period writes land clamped into the legal range
  function automatic logic [31:0] clamp_p(input logic [31:0] x);
    return x < 32'h20 ? 32'h20 : (x > 32'hAF0 ? 32'hAF0 : x);
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic hang(input string m);
    err_total++;
    $display("wrong value at %0t: %s", $time, m);
    end_of_test();
  endtask
  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    PSEL_I <= 1'h1;
    PENABLE_I <= 1'h0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    ack_dly <= 4'(rnd());
    @(posedge CLK_I);
    PENABLE_I <= 1'h1;
    n = 0;
    do @(posedge CLK_I); while (PREADY_O !== 1'h1 && ++n < 20);
    if (n >= 20) hang("no pready");
    rd = PSLVERR_O ? 32'hFFFFFFFF : PRDATA_O;
    PSEL_I <= 1'h0;
    PENABLE_I <= 1'h0;
  endtask
  // Wait for pull-down (0), scan (1) or poll (2) to reach v; n counts cycles
  task automatic wait_sig(input int which, input logic v, input int lim);
    logic s;
    n = 0;
    do
    begin
      @(negedge CLK_I);
      s = which == 0 ? REQ_PULLDOWN_O : (which == 1 ? SCAN_START_O : POLL_REQ_O);
      n++;
    end
    while (s !== v && n < lim);
    if (s !== v) hang("wait ran out");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = '0;
    {SLEEP_REQUEST_PIN_I, STACK_BUSY_I, JOINED_I, ser_go, pend, ack_dly} = '0;
    repeat (12) @(posedge CLK_I);
    RST_N_I <= 1'h1;
    STACK_BUSY_I <= 1'h1;
    SLEEP_REQUEST_PIN_I <= 1'h1;
    // Reset values, then an unmapped word that must be refused
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h0, 12'(i * 4), 32'h0);
      chk(rd, i == 1 ? 32'h20 : i == 2 ? 1 : i == 4 ? 5 : 0, "reset");
    end
    apb(1'h0, 12'h040, 32'h0);
    chk(rd, 32'hFFFFFFFF, "unmapped");
    chk(32'(REQ_PULLDOWN_O), 32'h0, "mode 0 slept");
    apb(1'h1, `ENS_OFF_CONFIG, 32'h7);
    apb(1'h1, `ENS_OFF_MODE, 32'h1);
    // Pin sleep, first unjoined, then joined
    for (int j = 0; j < 2; j++)
    begin
      @(posedge CLK_I);
      STACK_BUSY_I <= 1'h1;
      SLEEP_REQUEST_PIN_I <= 1'h1;
      JOINED_I <= j[0];
      repeat (30) @(negedge CLK_I);
      chk(32'(REQ_PULLDOWN_O), 32'h0, "slept while busy");
      @(posedge CLK_I);
      STACK_BUSY_I <= 1'h0;
      wait_sig(0, 1'h1, 20);
      chk(32'({CTS_O, LINK_LED_O, AWAKE_O}), 32'h4, "asleep pins");
      @(posedge CLK_I);
      SLEEP_REQUEST_PIN_I <= 1'h0;
      if (j == 0) wait_sig(1, 1'h1, 10);
      wait_sig(0, 1'h0, 10);
      chk(32'({CTS_O, LINK_LED_O, AWAKE_O}), 32'h3, "awake pins");
      if (j == 1) wait_sig(2, 1'h1, 20);
    end
    wait_sig(2, 1'h0, 3);
    wait_sig(2, 1'h1, 200);
    chk(32'(n >= 91 && n <= 100), 32'h1, "poll period");
    // Period clamp with corners and random values, count floor
    for (int i = 0; i < 4; i++)
    begin
      v = i == 0 ? 32'h10 : (i == 1 ? 32'hFFF : rnd() & 32'hFFF);
      apb(1'h1, `ENS_OFF_PERIOD, v);
      apb(1'h0, `ENS_OFF_PERIOD, 32'h0);
      chk(rd, clamp_p(v), "period");
    end
    apb(1'h1, `ENS_OFF_COUNT, 32'h0);
    apb(1'h0, `ENS_OFF_COUNT, 32'h0);
    chk(rd, 32'h1, "count floor");
    // Cyclic mode 4: the pin does not wake it
    apb(1'h1, `ENS_OFF_PERIOD, 32'h20);
    apb(1'h1, `ENS_OFF_MODE, 32'h4);
    wait_sig(0, 1'h1, 400);
    @(posedge CLK_I);
    SLEEP_REQUEST_PIN_I <= 1'h1;
    repeat (20) @(posedge CLK_I);
    SLEEP_REQUEST_PIN_I <= 1'h0;
    wait_sig(0, 1'h0, 400);
    chk(32'(n >= 289 && n <= 309), 32'h1, "short sleep");
    wait_sig(0, 1'h1, 60);
    // Extended sleep lasts period times count
    apb(1'h1, `ENS_OFF_OPTIONS, 32'h4);
    apb(1'h1, `ENS_OFF_COUNT, 32'h2);
    wait_sig(0, 1'h0, 700);
    wait_sig(0, 1'h1, 60);
    wait_sig(0, 1'h0, 700);
    chk(32'(n >= 630 && n <= 650), 32'h1, "extended sleep");
    // Mode 5: early wake on a falling pin, data holds it awake
    apb(1'h1, `ENS_OFF_OPTIONS, 32'h0);
    apb(1'h1, `ENS_OFF_COUNT, 32'h1);
    apb(1'h1, `ENS_OFF_MODE, 32'h5);
    pend <= 1'h1;
    wait_sig(0, 1'h1, 400);
    @(posedge CLK_I);
    SLEEP_REQUEST_PIN_I <= 1'h1;
    repeat (10) @(posedge CLK_I);
    SLEEP_REQUEST_PIN_I <= 1'h0;
    wait_sig(0, 1'h0, 12);
    @(posedge CLK_I);
    ser_go <= 1'h1;
    @(posedge CLK_I);
    ser_go <= 1'h0;
    repeat (30) @(negedge CLK_I);
    chk(32'(REQ_PULLDOWN_O), 32'h0, "hold timer");
    apb(1'h1, `ENS_OFF_COMMAND, 32'h1);
    wait_sig(0, 1'h1, 10);
    end_of_test();
  end
endmodule
